// ### src/epi_pkg.sv
// Package for the external pin interrupt block: offsets, fields, types
package epi_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  // Register offsets (index on the plain register port)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  // Control register field positions
  localparam int unsigned BIT_MODE = 0;
  localparam int unsigned BIT_IE   = 1;
  localparam int unsigned BIT_ACK  = 2;
  localparam int unsigned BIT_FLAG = 3;
  localparam int unsigned BIT_PE   = 4;
  localparam int unsigned BIT_POL  = 5;
  localparam int unsigned BIT_PDD  = 6;
  localparam int unsigned BIT_RSV  = 7;
  // Event status bits
  localparam int unsigned EV_REQ   = 0;
  localparam int unsigned EV_ACK   = 1;
  localparam int unsigned EV_W     = 2;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [1:0] RST_EV    = 2'h0;

  typedef struct packed {
    logic       pull_disable;
    logic       edge_polarity;
    logic       pin_function_enable;
    logic       request_interrupt_enable;
    logic       detection_mode;
  } epi_ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } epi_bus_s;
endpackage

// ### src/epi_top.sv
// External interrupt request pin logic with register port and event irq
//
// Contract
// - Pin function enable gates all request events
// - Pull on unless pull-disable set, when enabled
// - Polarity bit: 0 falling/low, 1 rising/high
// - Rising uses pull-down, falling uses pull-up
// - Mode bit: edges only, or edges plus levels
// - Request flag set on qualifying pin event
// - Writing acknowledge one clears flag; reads zero
// - Level mode: acknowledge ignored while pin asserted
// - Interrupt request equals flag and enable
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module epi_top (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  input  wire logic [epi_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [epi_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [epi_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                      i_req_pin,
  output logic                           o_pull_up_en,
  output logic                           o_pull_down_en,
  output logic                           o_cpu_irq,
  output logic                           o_evt_irq
);
  epi_pkg::epi_bus_s  bus;
  epi_pkg::epi_ctrl_s ctrl_ff, nxt_ctrl;
  logic               flag_ff, nxt_flag;
  logic [1:0]         sync_ff;
  logic               pin_q_ff;
  logic [epi_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [epi_pkg::EV_W-1:0]   stat_ff, nxt_stat, mask_ff, nxt_mask;
  logic               pu_ff, nxt_pu, pd_ff, nxt_pd;
  logic               irq_ff, nxt_irq, eirq_ff, nxt_eirq;
  logic               pin_now, active, edge_hit, lvl_hit, event_hit;
  logic               ack_wr;
  logic [1:0]         nxt_sync;
  logic               nxt_pin_q;

  // Strobe qualified by register index; shared by the write and status-clear decoders, not the read data case
  function automatic logic reg_sel(
    input logic                       strobe,
    input logic [epi_pkg::ADDR_W-1:0] addr,
    input logic [epi_pkg::ADDR_W-1:0] ofs
  );
    return strobe && (addr == ofs);
  endfunction

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Synchroniser; the first stage feeds only the second
  // two-stage sync
  always_comb begin
    nxt_sync  = {sync_ff[0], i_req_pin};
    nxt_pin_q = sync_ff[1];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync_ff  <= 2'h0;
      pin_q_ff <= 1'b0;
    end else begin
      sync_ff  <= nxt_sync;
      pin_q_ff <= nxt_pin_q;
    end
  end

  always_comb begin
    pin_now = sync_ff[1];
    active   = ctrl_ff.edge_polarity ? pin_now : ~pin_now;
    edge_hit = ctrl_ff.edge_polarity ? (pin_now & ~pin_q_ff)
                                     : (~pin_now & pin_q_ff);
    lvl_hit  = ctrl_ff.detection_mode & active;
    event_hit = ctrl_ff.pin_function_enable & (edge_hit | lvl_hit);
  end

  assign ack_wr = reg_sel(bus.wr, bus.addr, epi_pkg::OFS_CTRL)
                  && bus.wdata[epi_pkg::BIT_ACK];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_flag = flag_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    if (reg_sel(bus.wr, bus.addr, epi_pkg::OFS_CTRL)) begin
      nxt_ctrl.pull_disable  = bus.wdata[epi_pkg::BIT_PDD];
      nxt_ctrl.edge_polarity = bus.wdata[epi_pkg::BIT_POL];
      nxt_ctrl.pin_function_enable = bus.wdata[epi_pkg::BIT_PE];
      nxt_ctrl.request_interrupt_enable = bus.wdata[epi_pkg::BIT_IE];
      nxt_ctrl.detection_mode = bus.wdata[epi_pkg::BIT_MODE];
    end
    if (reg_sel(bus.wr, bus.addr, epi_pkg::OFS_MASK))
      nxt_mask = bus.wdata[epi_pkg::EV_W-1:0];
    if (ack_wr)
      nxt_flag = 1'b0;
    // level mode holds flag; set wins over clear
    if (ack_wr && ctrl_ff.detection_mode && active
        && ctrl_ff.pin_function_enable)
      nxt_flag = 1'b1;
    if (event_hit)
      nxt_flag = 1'b1;
    // Read of status clears it, but a new event in that cycle survives
    if (reg_sel(bus.rd, bus.addr, epi_pkg::OFS_STAT))
      nxt_stat = epi_pkg::RST_EV;
    if (event_hit)
      nxt_stat[epi_pkg::EV_REQ] = 1'b1;
    if (ack_wr)
      nxt_stat[epi_pkg::EV_ACK] = 1'b1;
  end

  always_comb begin
    nxt_rdata = epi_pkg::RST_BYTE;
    if (bus.rd) begin
      unique case (bus.addr)
        // ack reads zero, bit seven zero
        epi_pkg::OFS_CTRL: begin
          nxt_rdata[epi_pkg::BIT_PDD]  = ctrl_ff.pull_disable;
          nxt_rdata[epi_pkg::BIT_POL]  = ctrl_ff.edge_polarity;
          nxt_rdata[epi_pkg::BIT_PE]   = ctrl_ff.pin_function_enable;
          nxt_rdata[epi_pkg::BIT_FLAG] = flag_ff;
          nxt_rdata[epi_pkg::BIT_IE]   =
            ctrl_ff.request_interrupt_enable;
          nxt_rdata[epi_pkg::BIT_MODE] = ctrl_ff.detection_mode;
        end
        epi_pkg::OFS_STAT: nxt_rdata[epi_pkg::EV_W-1:0] = stat_ff;
        epi_pkg::OFS_MASK: nxt_rdata[epi_pkg::EV_W-1:0] = mask_ff;
        default:           nxt_rdata = epi_pkg::RST_BYTE;
      endcase
    end
    nxt_pu = ctrl_ff.pin_function_enable & ~ctrl_ff.pull_disable
             & ~ctrl_ff.edge_polarity;
    nxt_pd = ctrl_ff.pin_function_enable & ~ctrl_ff.pull_disable
             & ctrl_ff.edge_polarity;
    nxt_irq  = nxt_flag & nxt_ctrl.request_interrupt_enable;
    nxt_eirq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_ff  <= '0;
      flag_ff  <= 1'b0;
      stat_ff  <= epi_pkg::RST_EV;
      mask_ff  <= epi_pkg::RST_EV;
      rdata_ff <= epi_pkg::RST_BYTE;
      pu_ff    <= 1'b0;
      pd_ff    <= 1'b0;
      irq_ff   <= 1'b0;
      eirq_ff  <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      flag_ff  <= nxt_flag;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
      pu_ff    <= nxt_pu;
      pd_ff    <= nxt_pd;
      irq_ff   <= nxt_irq;
      eirq_ff  <= nxt_eirq;
    end
  end

  assign o_rdata        = rdata_ff;
  assign o_pull_up_en   = pu_ff;
  assign o_pull_down_en = pd_ff;
  assign o_cpu_irq      = irq_ff;
  assign o_evt_irq      = eirq_ff;

  sequence rise_seen_s;
    ctrl_ff.pin_function_enable && ctrl_ff.edge_polarity
      && !pin_q_ff && sync_ff[1];
  endsequence

  event_sets_flag_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    rise_seen_s |=> flag_ff)
    else $error("rising edge did not set flag");

  disabled_no_flag_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_ff.pin_function_enable && !flag_ff && !bus.wr |=> !flag_ff)
    else $error("flag set with pin disabled");

  ack_clears_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ack_wr && !ctrl_ff.detection_mode && !event_hit |=> !flag_ff)
    else $error("acknowledge did not clear flag");

  level_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ack_wr && ctrl_ff.detection_mode && ctrl_ff.pin_function_enable
      && active |=> flag_ff)
    else $error("flag cleared while level asserted");

  irq_follow_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_cpu_irq == (flag_ff && ctrl_ff.request_interrupt_enable))
    else $error("irq does not track flag and enable");

  pull_dir_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 !(o_pull_up_en && o_pull_down_en))
    else $error("both pulls on");

  pull_off_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ctrl_ff.pull_disable |=> !o_pull_up_en && !o_pull_down_en)
    else $error("pull on while disabled");

  low_level_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ctrl_ff.pin_function_enable && ctrl_ff.detection_mode
      && !ctrl_ff.edge_polarity && !sync_ff[1] |=> flag_ff)
    else $error("low level did not set flag");

  read_bit7_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    bus.rd |=> !o_rdata[epi_pkg::BIT_RSV] && !o_rdata[epi_pkg::BIT_ACK])
    else $error("reserved or ack bit read nonzero");

  sequence fall_seen_s;
    ctrl_ff.pin_function_enable && !ctrl_ff.edge_polarity
      && pin_q_ff && !sync_ff[1];
  endsequence

  fall_sets_flag_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    fall_seen_s |=> flag_ff)
    else $error("falling edge did not set flag");

  high_level_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ctrl_ff.pin_function_enable && ctrl_ff.detection_mode
      && ctrl_ff.edge_polarity && sync_ff[1] |=> flag_ff)
    else $error("high level did not set flag");

  // Edge-only mode must ignore a steady asserted level
  edge_only_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_ff.detection_mode && !flag_ff && !edge_hit && !bus.wr
      |=> !flag_ff)
    else $error("flag set without an edge");

  flag_sticky_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    flag_ff && !ack_wr |=> flag_ff)
    else $error("flag dropped without acknowledge");

  flag_read_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    reg_sel(bus.rd, bus.addr, epi_pkg::OFS_CTRL)
      |=> o_rdata[epi_pkg::BIT_FLAG] == $past(flag_ff))
    else $error("read flag differs from flag");

  irq_off_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !nxt_ctrl.request_interrupt_enable |=> !o_cpu_irq)
    else $error("irq raised while disabled");

  pull_up_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ctrl_ff.pin_function_enable && !ctrl_ff.pull_disable
      && !ctrl_ff.edge_polarity |=> o_pull_up_en && !o_pull_down_en)
    else $error("falling mode lacks pull-up");

  pull_down_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ctrl_ff.pin_function_enable && !ctrl_ff.pull_disable
      && ctrl_ff.edge_polarity |=> o_pull_down_en && !o_pull_up_en)
    else $error("rising mode lacks pull-down");

  // A pin not used for requests must not load the board
  pull_idle_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_ff.pin_function_enable |=> !o_pull_up_en && !o_pull_down_en)
    else $error("pull on while pin disabled");

  disabled_quiet_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_ff.pin_function_enable |-> !event_hit)
    else $error("event seen while pin disabled");

  sync_chain_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    ##1 sync_ff[1] == $past(sync_ff[0]) && pin_q_ff == $past(sync_ff[1]))
    else $error("synchroniser stages skipped");

  // Checked without disable, since it is about reset itself
  reset_clear_a: assert property (
    @(posedge i_clk_sys)
    i_rst |=> ctrl_ff == '0 && !flag_ff && !o_cpu_irq)
    else $error("reset did not clear control");
endmodule
`default_nettype wire

// ### bench/epi_pin_model.sv
// Behavioural external device on the request pin
`timescale 1ns/100ps
`default_nettype none
module epi_pin_model (
  input  wire logic i_drive,
  input  wire logic i_level,
  input  wire logic i_pull_up_en,
  input  wire logic i_pull_down_en,
  output logic      o_pin
);
  logic last = 1'b0;
  always_comb begin
    if (i_drive) begin
      o_pin = i_level;
    end else if (i_pull_up_en) begin
      o_pin = 1'b1;
    end else if (i_pull_down_en) begin
      o_pin = 1'b0;
    end else begin
      o_pin = ~last;
    end
  end
  // Floating pin must not echo the old level
  always @(negedge i_drive) begin
    last = i_level;
  end
endmodule
`default_nettype wire

// ### bench/external_pin_interrupt_tb.sv
// Self-checking bench for the external pin interrupt block
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_tb;
  localparam logic [3:0] CT = epi_pkg::OFS_CTRL;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       lvl = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       pin, pu, pd, cirq, eirq;
  int         num_errors = 0;
  int         tests_run = 0;
  always #2 clk = ~clk;
  epi_top u_epi_top (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_req_pin(pin), .o_pull_up_en(pu), .o_pull_down_en(pd),
    .o_cpu_irq(cirq), .o_evt_irq(eirq));
  epi_pin_model u_epi_pin_model (.i_drive(1'b1), .i_level(lvl),
    .i_pull_up_en(pu), .i_pull_down_en(pd), .o_pin(pin));
  task automatic chk(input string nm, input logic [7:0] ex, got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] ex);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", ex, rdata);
  endtask
  // Level held five clocks, beyond sync plus detect
  task automatic setpin(input logic v);
    @(posedge clk);
    lvl <= v;
    idle(5);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(CT, 8'h00);
    chk("pulls", 8'h00, {6'h0, pu, pd});
    setpin(1'b0);
    setpin(1'b1);
    rreg(CT, 8'h00);
    note("disabled");
    wreg(CT, 8'h12);
    idle(1);
    chk("pulls", 8'h02, {6'h0, pu, pd});
    setpin(1'b0);
    rreg(CT, 8'h1A);
    chk("irq", 8'h01, {7'h0, cirq});
    wreg(CT, 8'h10);
    chk("irq", 8'h00, {7'h0, cirq});
    wreg(CT, 8'h12);
    rreg(CT, 8'h1A);
    wreg(CT, 8'h16);
    rreg(CT, 8'h12);
    chk("irq", 8'h00, {7'h0, cirq});
    note("falling");
    wreg(CT, 8'h52);
    idle(1);
    chk("pulls", 8'h00, {6'h0, pu, pd});
    wreg(CT, 8'h33);
    idle(1);
    chk("pulls", 8'h01, {6'h0, pu, pd});
    setpin(1'b1);
    rreg(CT, 8'h3B);
    wreg(CT, 8'h37);
    rreg(CT, 8'h3B);
    setpin(1'b0);
    wreg(CT, 8'h37);
    rreg(CT, 8'h33);
    note("level");
    wreg(epi_pkg::OFS_MASK, 8'h03);
    rreg(epi_pkg::OFS_MASK, 8'h03);
    chk("evt", 8'h01, {7'h0, eirq});
    rreg(epi_pkg::OFS_STAT, 8'h03);
    idle(1);
    chk("evt", 8'h00, {7'h0, eirq});
    rreg(epi_pkg::OFS_STAT, 8'h00);
    rreg(4'hF, 8'h00);
    note("events");
    complete_run();
  end
endmodule
`default_nettype wire
